// File: logic/srx_regs.svh
// Register offsets, field positions, reset values and timing of the serial unit
`ifndef SRX_REGS_SVH
`define SRX_REGS_SVH
`define SRX_OFS_BDH    3'h0
`define SRX_OFS_BDL    3'h1
`define SRX_OFS_CR1    3'h2
`define SRX_OFS_CR2    3'h3
`define SRX_OFS_SR1    3'h4
`define SRX_OFS_SR2    3'h5
`define SRX_OFS_DRL    3'h7
`define SRX_SR1_TDRE   7
`define SRX_SR1_TC     6
`define SRX_SR1_RECEIVE_FULL_FLAG   5
`define SRX_SR1_OVR    3
`define SRX_SR1_FE     1
`define SRX_SR1_PF     0
`define SRX_SR2_ALTERNATE_MAP_SELECT   7
`define SRX_SR2_TRANSMIT_POLARITY  4
`define SRX_CR1_PE     1
`define SRX_CR1_PT     0
`define SRX_CR2_TE     3
`define SRX_CR2_RE     2
`define SRX_ACR2_IR    0
`define SRX_EV_RX      0
`define SRX_EV_FE      1
`define SRX_EV_PF      2
`define SRX_EV_OVR     3
`define SRX_BD_RST     13'h0004
`define SRX_SUB_MID    4'h7
`define SRX_SUB_LAST   4'hf
`define SRX_IR_FIRST   4'h6
`define SRX_IR_LAST    4'h8
`endif

// File: logic/srx_pkg.sv
// Types shared by the serial unit modules
package srx_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_START, ST_DATA, ST_PAR, ST_STOP} srx_st_e;

  typedef struct packed {
    srx_st_e    st;
    logic [3:0] sub;
    logic [2:0] bits;
    logic [7:0] shift;
    logic       par;
    logic       line;
  } srx_tx_s;

  typedef struct packed {
    logic        rx_s0;
    logic        rx_s1;
    logic [12:0] bd;
    logic [7:0]  cr1;
    logic [7:0]  cr2;
    logic        alternate_map_select;
    logic        transmit_polarity;
    logic        ir;
    logic [3:0]  mask;
    logic [3:0]  evt;
    logic [12:0] div;
    logic        tick;
    srx_st_e     st;
    logic [3:0]  sub;
    logic [2:0]  bits;
    logic [7:0]  shift;
    logic        par;
    logic [7:0]  rdr;
    logic        receive_full_flag;
    logic        ovr;
    logic        fe;
    logic        pf;
    logic        armed;
    logic [7:0]  tdr;
    logic        tdre;
    logic        tc;
    logic        load;
    logic [7:0]  rdata;
    logic        irq;
    logic        txd;
  } srx_top_s;
endpackage

// File: logic/srx_tx_if.sv
// Link between the register block and the transmit encoder
`timescale 1ns/1ps
interface srx_tx_if (
  input wire logic clk,
  input wire logic rst_n
);
  logic       ce;
  logic       tick;
  logic       load;
  logic [7:0] data;
  logic       pe;
  logic       pt;
  logic       pol;
  logic       ir;
  logic       busy;
  logic       line;
  modport ctl (input clk, rst_n, busy, line, output ce, tick, load, data, pe, pt, pol, ir);
  modport tx (input clk, rst_n, ce, tick, load, data, pe, pt, pol, ir, output busy, line);
endinterface

// File: logic/srx_tx.sv
// Transmit encoder: framing, parity, NRZ or infrared pulse shaping, polarity
`timescale 1ns/1ps
`include "srx_regs.svh"
module srx_tx (
  srx_tx_if.tx bus
);
  srx_pkg::srx_tx_s q;
  srx_pkg::srx_tx_s d;
  logic             cur;
  logic             pulse;

  always_comb begin
    d = q;
    case (q.st)
      srx_pkg::ST_START: cur = 1'b0;
      srx_pkg::ST_DATA:  cur = q.shift[0];
      srx_pkg::ST_PAR:   cur = q.par;
      default:           cur = 1'b1;
    endcase
    pulse = (q.st != srx_pkg::ST_IDLE) && !cur &&
            (q.sub >= `SRX_IR_FIRST) && (q.sub <= `SRX_IR_LAST);
    if (bus.ce) begin
      if (q.st == srx_pkg::ST_IDLE) begin
        if (bus.load) begin
          d.st    = srx_pkg::ST_START;
          d.sub   = 4'h0;
          d.shift = bus.data;
          d.par   = (^bus.data) ^ bus.pt;
        end
      end else if (bus.tick) begin
        d.sub = q.sub + 4'h1;
        if (q.sub == `SRX_SUB_LAST) begin
          unique case (q.st)
            srx_pkg::ST_START: begin
              d.st   = srx_pkg::ST_DATA;
              d.bits = 3'h0;
            end
            srx_pkg::ST_DATA: begin
              d.shift = {1'b0, q.shift[7:1]};
              d.bits  = q.bits + 3'h1;
              if (q.bits == 3'h7) begin
                d.st = bus.pe ? srx_pkg::ST_PAR : srx_pkg::ST_STOP;
              end
            end
            srx_pkg::ST_PAR: d.st = srx_pkg::ST_STOP;
            default:         d.st = srx_pkg::ST_IDLE;
          endcase
        end
      end
      // Pulse only for a zero; a one leaves the line at its idle level
      d.line = bus.ir ? (pulse ^ bus.pol) : (cur ^ bus.pol);
    end
    if (!bus.rst_n) begin
      d      = '0;
      d.line = 1'b1;
    end
  end

  always_ff @(posedge bus.clk) begin
    q <= d;
  end

  assign bus.busy = (q.st != srx_pkg::ST_IDLE);
  assign bus.line = q.line;

  nrz_polarity_a: assert property (
    @(posedge bus.clk) disable iff (!bus.rst_n)
    bus.ce && !bus.ir |=> bus.line == ($past(cur) ^ $past(bus.pol)))
    else $error("NRZ line level does not follow bit and polarity");

  ir_zero_pulse_a: assert property (
    @(posedge bus.clk) disable iff (!bus.rst_n)
    bus.ce && bus.ir && bus.busy && !cur && q.sub == 4'h7 |=> bus.line == !$past(bus.pol))
    else $error("Infrared zero not sent as a centred pulse");

  ir_one_idle_a: assert property (
    @(posedge bus.clk) disable iff (!bus.rst_n)
    bus.ce && bus.ir && cur |=> bus.line == $past(bus.pol))
    else $error("Infrared one does not leave the line idle");
endmodule

// File: logic/srx_top.sv
// Serial unit: register file, receiver with error flags, transmitter control
`timescale 1ns/1ps
`include "srx_regs.svh"
// Summary of operation
// - A zero sampled at the stop position sets the framing error flag.
// - Framing error rises with receive-full, never on an overrun character.
// - While framing error stands, no new reception starts.
// - Status one read with flag set, then data low read, clears framing error.
// - Enabled parity mismatching the selected type sets the parity error flag.
// - Parity error rises with receive-full, never on an overrun character.
// - Status one read then data low read clears the parity error flag.
// - Alternate map bit swaps offsets 0 to 2 between baud/control and alternate set.
// - Reset leaves the alternate map off, giving the legacy arrangement.
// - NRZ: one is mark, zero is space; polarity bit swaps them.
// - Infrared normal: zero is a centred high pulse, one stays low.
// - Infrared inverted: zero is a centred low pulse, one stays high.
module srx_top (
  input  wire logic       CLK,
  input  wire logic       RST_N,
  input  wire logic       CE,
  input  wire logic [2:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  input  wire logic       RXD,
  output logic      [7:0] RDATA,
  output logic            TXD,
  output logic            IRQ
);
  srx_pkg::srx_top_s q;
  srx_pkg::srx_top_s d;
  logic              samp;
  logic              char_done;
  logic              frame_bad;
  logic              par_bad;
  logic              rd_sr1;
  logic              rd_drl;
  logic              clr_ok;
  logic              ovr_hit;

  srx_tx_if txi (.clk(CLK), .rst_n(RST_N));

  srx_tx u_tx (
    .bus(txi)
  );

  // ****************************************************************
  // Register read decode
  // ****************************************************************
  function automatic logic [7:0] reg_read(input logic [2:0] a, input srx_pkg::srx_top_s s);
    logic [7:0] r;
    r = 8'h00;
    case (a)
      `SRX_OFS_BDH: r = s.alternate_map_select ? {4'h0, s.evt} : {3'h0, s.bd[12:8]};
      `SRX_OFS_BDL: r = s.alternate_map_select ? {4'h0, s.mask} : s.bd[7:0];
      `SRX_OFS_CR1: r = s.alternate_map_select ? {7'h00, s.ir} : s.cr1;
      `SRX_OFS_CR2: r = s.cr2;
      `SRX_OFS_SR1: begin
        r[`SRX_SR1_TDRE] = s.tdre;
        r[`SRX_SR1_TC]   = s.tc;
        r[`SRX_SR1_RECEIVE_FULL_FLAG] = s.receive_full_flag;
        r[`SRX_SR1_OVR]  = s.ovr;
        r[`SRX_SR1_FE]   = s.fe;
        r[`SRX_SR1_PF]   = s.pf;
      end
      `SRX_OFS_SR2: begin
        r[`SRX_SR2_ALTERNATE_MAP_SELECT]  = s.alternate_map_select;
        r[`SRX_SR2_TRANSMIT_POLARITY] = s.transmit_polarity;
      end
      `SRX_OFS_DRL: r = s.rdr;
      default:      r = 8'h00;
    endcase
    return r;
  endfunction

  // ****************************************************************
  // Receive events and the flag clearing sequence
  // ****************************************************************
  assign samp      = CE && q.tick && (q.sub == `SRX_SUB_MID);
  assign char_done = samp && (q.st == srx_pkg::ST_STOP);
  assign frame_bad = !q.rx_s1;
  assign par_bad   = q.cr1[`SRX_CR1_PE] && (((^q.shift) ^ q.par) != q.cr1[`SRX_CR1_PT]);
  assign rd_sr1    = CE && RD && (ADDR == `SRX_OFS_SR1);
  assign rd_drl    = CE && RD && (ADDR == `SRX_OFS_DRL);
  assign clr_ok    = rd_drl && q.armed;
  // A read that clears the full flag this cycle makes room for the new character
  assign ovr_hit   = char_done && q.receive_full_flag && !clr_ok;

  always_comb begin
    d = q;
    if (CE) begin
      d.rx_s0 = RXD;
      d.rx_s1 = q.rx_s0;

      // ************************************************************
      // Oversampling tick, sixteen per bit; a zero divisor stops it
      // ************************************************************
      d.tick = 1'b0;
      if (q.bd != 13'h0000) begin
        if (q.div >= q.bd - 13'h0001) begin
          d.div  = 13'h0000;
          d.tick = 1'b1;
        end else begin
          d.div = q.div + 13'h0001;
        end
      end

      // ************************************************************
      // Receiver
      // ************************************************************
      if (q.tick) begin
        unique case (q.st)
          srx_pkg::ST_IDLE: begin
            if (q.cr2[`SRX_CR2_RE] && !q.fe && !q.rx_s1) begin
              d.st  = srx_pkg::ST_START;
              d.sub = 4'h0;
            end
          end
          srx_pkg::ST_START: begin
            d.sub = q.sub + 4'h1;
            // A glitch shorter than half a bit is not a start bit
            if (q.sub == `SRX_SUB_MID && q.rx_s1) begin
              d.st = srx_pkg::ST_IDLE;
            end else if (q.sub == `SRX_SUB_LAST) begin
              d.st   = srx_pkg::ST_DATA;
              d.bits = 3'h0;
            end
          end
          srx_pkg::ST_DATA: begin
            d.sub = q.sub + 4'h1;
            if (q.sub == `SRX_SUB_MID) begin
              d.shift = {q.rx_s1, q.shift[7:1]};
            end
            if (q.sub == `SRX_SUB_LAST) begin
              d.bits = q.bits + 3'h1;
              if (q.bits == 3'h7) begin
                d.st = q.cr1[`SRX_CR1_PE] ? srx_pkg::ST_PAR : srx_pkg::ST_STOP;
              end
            end
          end
          srx_pkg::ST_PAR: begin
            d.sub = q.sub + 4'h1;
            if (q.sub == `SRX_SUB_MID) begin
              d.par = q.rx_s1;
            end
            if (q.sub == `SRX_SUB_LAST) begin
              d.st = srx_pkg::ST_STOP;
            end
          end
          srx_pkg::ST_STOP: begin
            d.sub = q.sub + 4'h1;
            // Back to idle at mid stop so a tight next start is not missed
            if (q.sub == `SRX_SUB_MID) begin
              d.st = srx_pkg::ST_IDLE;
            end
          end
          default: d.st = srx_pkg::ST_IDLE;
        endcase
      end

      // ************************************************************
      // Two-read clearing of the receive flags
      // ************************************************************
      if (rd_sr1 && (q.fe || q.pf || q.receive_full_flag || q.ovr)) begin
        d.armed = 1'b1;
      end
      if (clr_ok) begin
        d.armed = 1'b0;
        d.receive_full_flag  = 1'b0;
        d.fe    = 1'b0;
        d.pf    = 1'b0;
        d.ovr   = 1'b0;
      end

      // ************************************************************
      // Transmit hand-off to the encoder
      // ************************************************************
      d.load = 1'b0;
      if (!q.tdre && q.cr2[`SRX_CR2_TE] && !txi.busy && !q.load) begin
        d.load = 1'b1;
        d.tdre = 1'b1;
        d.tc   = 1'b0;
      end else if (q.tdre && !q.load && !txi.busy) begin
        d.tc = 1'b1;
      end

      // ************************************************************
      // Register writes
      // ************************************************************
      if (WR) begin
        case (ADDR)
          `SRX_OFS_BDH: begin
            if (q.alternate_map_select) begin
              d.evt = q.evt & ~WDATA[3:0];
            end else begin
              d.bd[12:8] = WDATA[4:0];
            end
          end
          `SRX_OFS_BDL: begin
            if (q.alternate_map_select) begin
              d.mask = WDATA[3:0];
            end else begin
              d.bd[7:0] = WDATA;
            end
          end
          `SRX_OFS_CR1: begin
            if (q.alternate_map_select) begin
              d.ir = WDATA[`SRX_ACR2_IR];
            end else begin
              d.cr1 = WDATA;
            end
          end
          `SRX_OFS_CR2: d.cr2 = WDATA;
          `SRX_OFS_SR2: begin
            d.alternate_map_select  = WDATA[`SRX_SR2_ALTERNATE_MAP_SELECT];
            d.transmit_polarity = WDATA[`SRX_SR2_TRANSMIT_POLARITY];
          end
          `SRX_OFS_DRL: begin
            d.tdr  = WDATA;
            d.tdre = 1'b0;
            d.tc   = 1'b0;
          end
          default: d.tdr = q.tdr;
        endcase
      end

      // ************************************************************
      // Character completion; applied last so a set beats any clear
      // ************************************************************
      if (char_done) begin
        d.evt[`SRX_EV_RX] = 1'b1;
        if (ovr_hit) begin
          d.ovr              = 1'b1;
          d.evt[`SRX_EV_OVR] = 1'b1;
        end else begin
          d.rdr  = q.shift;
          d.receive_full_flag = 1'b1;
          d.fe   = frame_bad;
          d.pf   = par_bad;
          d.evt[`SRX_EV_FE] = q.evt[`SRX_EV_FE] | frame_bad;
          d.evt[`SRX_EV_PF] = q.evt[`SRX_EV_PF] | par_bad;
        end
      end

      d.txd   = txi.line;
      d.rdata = RD ? reg_read(ADDR, q) : 8'h00;
      d.irq   = |(d.evt & d.mask);
    end
    if (!RST_N) begin
      d       = '0;
      d.rx_s0 = 1'b1;
      d.rx_s1 = 1'b1;
      d.bd    = `SRX_BD_RST;
      d.tdre  = 1'b1;
      d.tc    = 1'b1;
      d.txd   = 1'b1;
    end
  end

  always_ff @(posedge CLK) begin
    q <= d;
  end

  assign txi.ce   = CE;
  assign txi.tick = q.tick;
  assign txi.load = q.load;
  assign txi.data = q.tdr;
  assign txi.pe   = q.cr1[`SRX_CR1_PE];
  assign txi.pt   = q.cr1[`SRX_CR1_PT];
  assign txi.pol  = q.transmit_polarity;
  assign txi.ir   = q.ir;

  assign RDATA = q.rdata;
  assign TXD   = q.txd;
  assign IRQ   = q.irq;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  sequence status_peek_s;
    rd_sr1 && (q.fe || q.pf);
  endsequence

  sequence data_read_s;
    rd_drl && !char_done;
  endsequence

  frame_err_set_a: assert property (
    char_done && !ovr_hit && frame_bad |=> q.fe && q.receive_full_flag)
    else $error("Zero stop bit did not set framing error");

  // A set in the cycle of the clearing read keeps full high, so no rise is required
  frame_with_full_a: assert property (
    $rose(q.fe) |-> q.receive_full_flag && $past(char_done))
    else $error("Framing error rose without receive full");

  rx_blocked_a: assert property (
    q.fe |-> q.st == srx_pkg::ST_IDLE)
    else $error("Reception running while framing error stands");

  flag_arm_a: assert property (
    status_peek_s |=> q.armed)
    else $error("Status read with error flag set did not arm clearing");

  // Any gap between the two reads is legal, so the armed state stands for step one
  flag_clear_seq_a: assert property (
    q.armed ##0 data_read_s |=> !q.fe && !q.pf && !q.receive_full_flag)
    else $error("Status then data read did not clear error flags");

  parity_err_set_a: assert property (
    char_done && !ovr_hit && par_bad |=> q.pf)
    else $error("Parity mismatch did not set parity error");

  parity_with_full_a: assert property (
    $rose(q.pf) |-> q.receive_full_flag && $past(char_done))
    else $error("Parity error rose without receive full");

  overrun_keep_a: assert property (
    ovr_hit && !RD |=> q.ovr && q.fe == $past(q.fe) && q.pf == $past(q.pf))
    else $error("Overrun character changed error flags");

  alt_map_read_a: assert property (
    CE && RD && ADDR == `SRX_OFS_BDH && q.alternate_map_select |=> RDATA == {4'h0, $past(q.evt)})
    else $error("Alternate map read returned wrong register");

  legacy_map_read_a: assert property (
    CE && RD && ADDR == `SRX_OFS_BDL && !q.alternate_map_select |=> RDATA == $past(q.bd[7:0]))
    else $error("Legacy map read returned wrong register");

  reset_map_a: assert property (
    @(posedge CLK) disable iff (1'b0) !RST_N |=> !q.alternate_map_select)
    else $error("Alternate map not off after reset");
endmodule

// File: testbench/srx_peer.sv
// Remote serial transmitter model that drives the receive line of the unit
`timescale 1ns/1ps
module srx_peer (
  input  wire logic clk,
  output logic      rxd
);
  // Divisor 1 gives one tick per clock, so one bit is 16 clocks
  localparam int BIT_CLKS = 16;

  // Line idles high between frames, as the pull-up would leave it
  initial rxd = 1'h1;

  // ****************************************
  // Frame generator
  // ****************************************
  task automatic send(input logic [7:0] d, input logic pe, input logic pt,
                      input logic bad_par, input logic bad_stop);
    logic [10:0] f;
    int          n;
    n = pe ? 11 : 10;
    if (pe) begin
      f = {~bad_stop, (^d) ^ pt ^ bad_par, d, 1'h0};
    end else begin
      f = {1'h1, ~bad_stop, d, 1'h0};
    end
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      rxd <= f[i];
      repeat (BIT_CLKS - 1) @(posedge clk);
    end
    @(posedge clk);
    rxd <= 1'h1;
    // Guard time so flags have landed before software looks
    repeat (2 * BIT_CLKS) @(posedge clk);
  endtask
endmodule

// File: testbench/tb.sv
// Self-checking bench for the serial unit: registers, receive flags, transmit shaping
`timescale 1ns/1ps
`include "srx_regs.svh"
module tb;
  logic       CLK;
  logic       RST_N;
  logic       CE;
  logic [2:0] ADDR;
  logic [7:0] WDATA;
  logic       WR;
  logic       RD;
  logic       RXD;
  logic [7:0] RDATA;
  logic       TXD;
  logic       IRQ;
  int         failures;
  int         check_count;

  srx_top srx_top_inst (.CLK(CLK), .RST_N(RST_N), .CE(CE), .ADDR(ADDR), .WDATA(WDATA),
                        .WR(WR), .RD(RD), .RXD(RXD), .RDATA(RDATA), .TXD(TXD), .IRQ(IRQ));
  srx_peer srx_peer_inst (.clk(CLK), .rxd(RXD));

  initial begin
    CLK = 1'h0;
    forever #25 CLK = ~CLK;
  end

  // ****************************************
  // Access and compare tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge CLK);
    ADDR  <= a;
    WDATA <= d;
    WR    <= 1'h1;
    @(posedge CLK);
    WR    <= 1'h0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge CLK);
    ADDR <= a;
    RD   <= 1'h1;
    @(posedge CLK);
    RD   <= 1'h0;
    #1;
    check(RDATA, e);
  endtask

  task automatic irq_is(input logic e);
    repeat (2) @(posedge CLK);
    #1;
    check({7'h0, IRQ}, {7'h0, e});
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Samples each bit twice: pulse tick (or mid-bit) and a quarter later
  task automatic tx_frame(input logic pol, input logic ir, input logic [7:0] d);
    logic [9:0] f;
    logic       idle;
    int         n;
    f = {1'h1, d, 1'h0};
    idle = ir ? pol : ~pol;
    n = 0;
    wr(`SRX_OFS_DRL, d);
    while (TXD === idle && n < 100) begin
      @(posedge CLK);
      #1;
      n++;
    end
    if (n >= 100) begin
      failures++;
      close_out();
    end else begin
      repeat (ir ? 1 : 8) @(posedge CLK);
      #1;
      for (int i = 0; i < 10; i++) begin
        check({7'h0, TXD}, {7'h0, ir ? (f[i] ? pol : ~pol) : f[i] ^ pol});
        repeat (4) @(posedge CLK);
        #1;
        check({7'h0, TXD}, {7'h0, ir ? pol : f[i] ^ pol});
        repeat (12) @(posedge CLK);
        #1;
      end
    end
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    RST_N = 1'h0;
    CE = 1'h1;
    ADDR = 3'h0;
    WDATA = 8'h00;
    WR = 1'h0;
    RD = 1'h0;
    failures = 0;
    check_count = 0;
    repeat (16) @(posedge CLK);
    RST_N <= 1'h1;
    rd(`SRX_OFS_BDH, 8'h00);
    rd(`SRX_OFS_BDL, 8'h04);
    rd(`SRX_OFS_SR1, 8'hc0);
    rd(`SRX_OFS_SR2, 8'h00);
    rd(3'h6, 8'h00);
    wr(`SRX_OFS_SR2, 8'h80);
    rd(`SRX_OFS_SR2, 8'h80);
    wr(3'h1, 8'h05);
    rd(3'h1, 8'h05);
    rd(3'h0, 8'h00);
    wr(`SRX_OFS_SR2, 8'h00);
    rd(`SRX_OFS_BDL, 8'h04);
    CE <= 1'h0;
    wr(`SRX_OFS_BDL, 8'h09);
    CE <= 1'h1;
    rd(`SRX_OFS_BDL, 8'h04);
    wr(`SRX_OFS_BDL, 8'h01);
    rd(`SRX_OFS_BDL, 8'h01);
    wr(`SRX_OFS_CR2, 8'h0c);
    $display("test registers done");
    // Both parity types, good and bad parity
    for (int k = 0; k < 4; k++) begin
      wr(`SRX_OFS_CR1, {7'h01, k[0]});
      srx_peer_inst.send(8'h3c + 8'(k), 1'h1, k[0], k[1], 1'h0);
      rd(`SRX_OFS_SR1, {7'h70, k[1]});
      rd(`SRX_OFS_DRL, 8'h3c + 8'(k));
      rd(`SRX_OFS_SR1, 8'hc0);
    end
    $display("test parity done");
    srx_peer_inst.send(8'h96, 1'h1, 1'h1, 1'h0, 1'h1);
    rd(`SRX_OFS_DRL, 8'h96);
    rd(`SRX_OFS_SR1, 8'he2);
    srx_peer_inst.send(8'h11, 1'h1, 1'h1, 1'h0, 1'h0);
    rd(`SRX_OFS_SR1, 8'he2);
    rd(`SRX_OFS_DRL, 8'h96);
    rd(`SRX_OFS_SR1, 8'hc0);
    $display("test framing done");
    wr(`SRX_OFS_SR2, 8'h80);
    wr(3'h0, 8'h0f);
    wr(3'h1, 8'h08);
    rd(3'h0, 8'h00);
    irq_is(1'h0);
    srx_peer_inst.send(8'h21, 1'h1, 1'h1, 1'h0, 1'h0);
    srx_peer_inst.send(8'h42, 1'h1, 1'h1, 1'h1, 1'h0);
    rd(3'h0, 8'h09);
    irq_is(1'h1);
    wr(3'h0, 8'h08);
    irq_is(1'h0);
    wr(3'h1, 8'h01);
    irq_is(1'h1);
    wr(3'h1, 8'h00);
    irq_is(1'h0);
    wr(`SRX_OFS_SR2, 8'h00);
    rd(`SRX_OFS_SR1, 8'he8);
    rd(`SRX_OFS_DRL, 8'h21);
    rd(`SRX_OFS_SR1, 8'hc0);
    $display("test overrun done");
    // Every format and polarity combination
    wr(`SRX_OFS_CR1, 8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(`SRX_OFS_SR2, {3'h4, k[0], 4'h0});
      wr(3'h2, {7'h00, k[1]});
      repeat (4) @(posedge CLK);
      tx_frame(k[0], k[1], 8'h4b ^ 8'(k));
    end
    $display("test transmit done");
    close_out();
  end
endmodule
